// *** src/kds_regs.svh ***
/*
 * Register offsets, field positions, reset values and timing counts
 * of the keypad and display scanner.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef KDS_REGS_SVH
`define KDS_REGS_SVH

`define KDS_CTRL_OFF     32'h0000_0000
`define KDS_STATUS_OFF   32'h0000_0004
`define KDS_KEY_OFF      32'h0000_0008
`define KDS_SEG_OFF      32'h0000_000C
`define KDS_TABLE_OFF    32'h0000_0020
`define KDS_TABLE_MASK   32'hFFFF_FFE0
`define KDS_SEG_WIN_BIT  15
`define KDS_CTRL_RESET   32'h0000_0001
`define KDS_CTRL_EN_BIT  0
`define KDS_CTRL_WIDE_BIT 1
`define KDS_CTRL_ACK_BIT 2
`define KDS_ST_VALID_BIT 0
`define KDS_ST_DBNC_BIT  1
`define KDS_TICK_MS      3
`define KDS_CLK_KHZ      100000
`define KDS_TICK_CYCLES  (`KDS_TICK_MS * `KDS_CLK_KHZ)
`define KDS_NARROW_COLS  7
`define KDS_KEY_COLS     4

`endif

// *** src/kds_pkg.sv ***
/*
 * Types shared by the keypad and display scanner files.
 * Needs none of the constants in the header.
 */
package kds_pkg;
	typedef enum logic [1:0] {
		SCAN_IDLE,
		SCAN_BLANK,
		SCAN_SELECT,
		SCAN_LOAD
	} scan_state_t;
	typedef logic [2:0] digit_idx_t;
	typedef logic [7:0] seg_t;
	typedef logic [4:0] row_t;
endpackage

// *** src/tick_gen.sv ***
/*
 * Periodic scan tick divider.
 * Assumes one clock, synchronous high reset and a clock enable.
 */
`timescale 1ns/100ps
module tick_gen #(
	parameter int PERIOD = 300000
) (
	input  wire logic core_clk,
	input  wire logic reset,
	input  wire logic clkEn,
	input  wire logic run,
	output logic      tick
);
	logic [31:0] count_reg;
	wire         wrap = (count_reg == 32'(PERIOD - 1));

	always_ff @(posedge core_clk) begin
		if (reset) begin
			count_reg <= 32'h0000_0000;
			tick      <= 1'b0;
		end else if (clkEn) begin
			tick <= run && wrap;
			if (!run || wrap) begin
				count_reg <= 32'h0000_0000;
			end else begin
				count_reg <= count_reg + 32'h0000_0001;
			end
		end
	end
endmodule

// *** src/key_debounce.sv ***
/*
 * Key detection, debounce and validation across scan ticks.
 * Assumes a one-cycle sample strobe with synchronised row inputs.
 */
`timescale 1ns/100ps
module key_debounce (
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic       clkEn,
	input  wire logic       sample,
	input  wire logic [2:0] column,
	input  wire logic [4:0] rowsLow,
	input  wire logic       colValid,
	input  wire logic       ackKey,
	output logic            keyValidFlag,
	output logic            debouncePendingFlag,
	output logic [7:0]      storedKeyCode
);
	logic [2:0] pressCol_reg;
	logic       heldKey_reg;
	wire        anyKey = (rowsLow != 5'h1F) && colValid;
	wire [7:0]  code   = {rowsLow, column};

	always_ff @(posedge core_clk) begin
		if (reset) begin
			keyValidFlag        <= 1'b0;
			debouncePendingFlag <= 1'b0;
			storedKeyCode       <= 8'h00;
			pressCol_reg        <= 3'h0;
			heldKey_reg         <= 1'b0;
		end else if (clkEn) begin
			// A held key stays locked after an acknowledge until release.
			if (sample && anyKey && !heldKey_reg) begin
				if (!debouncePendingFlag) begin
					storedKeyCode       <= code;
					debouncePendingFlag <= 1'b1;
					pressCol_reg        <= column;
				end else if (code == storedKeyCode) begin
					keyValidFlag <= 1'b1;
					heldKey_reg  <= 1'b1;
				end else begin
					debouncePendingFlag <= 1'b0;
				end
			end else if (sample && !anyKey && column == pressCol_reg) begin
				debouncePendingFlag <= 1'b0;
				keyValidFlag        <= 1'b0;
				heldKey_reg         <= 1'b0;
			end else if (ackKey && !(sample && anyKey && !heldKey_reg)) begin
				keyValidFlag <= 1'b0;
			end
		end
	end
endmodule

// *** src/keypad_display_scanner.sv ***
/*
 * Multiplexed display refresher and matrix keypad scanner, AHB-Lite
 * slave.
 * Assumes a single AHB-Lite master on core_clk and asynchronous rows.
 */
`timescale 1ns/100ps
`include "kds_regs.svh"
module keypad_display_scanner #(
	parameter int TICK_CYCLES = `KDS_TICK_CYCLES
) (
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        clkEn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [4:0]  rowSenseLines,
	output logic      [2:0]  digitSelectLines,
	output logic      [7:0]  segmentDrive,
	output logic      [6:0]  digitDrive
);
	kds_pkg::scan_state_t state_reg;
	kds_pkg::scan_state_t state_next;
	kds_pkg::seg_t        table_reg [8];
	kds_pkg::seg_t        segLatch_reg;
	kds_pkg::digit_idx_t  digit_reg;
	kds_pkg::row_t        rowMeta_reg;
	kds_pkg::row_t        rowSync_reg;
	logic [31:0]          ctrl_reg;
	logic                 wrPend_reg;
	logic [31:0]          wrAddr_reg;
	logic                 rdPend_reg;
	logic                 driveOn_reg;
	logic                 driveLead_reg;
	logic                 tick;
	logic                 keyValid;
	logic                 dbncPending;
	logic [7:0]           keyCode;

	function automatic logic [7:0] decodeLow(input logic [2:0] idx);
		decodeLow = ~(8'h01 << idx);
	endfunction

	// Bus address phase capture.
	wire accept   = hsel && hready && htrans[1];
	wire wrAccept = accept && hwrite;
	wire rdAccept = accept && !hwrite;

	// Write decode uses the latched data-phase address.
	wire segWin   = wrAddr_reg[`KDS_SEG_WIN_BIT];
	wire ctrlHit  = !segWin && (wrAddr_reg == `KDS_CTRL_OFF);
	wire tableHit = !segWin &&
		((wrAddr_reg & `KDS_TABLE_MASK) == `KDS_TABLE_OFF);
	wire [2:0] tableIdx = wrAddr_reg[4:2];
	wire segWrite = wrPend_reg && segWin;
	wire ackKey   = wrPend_reg && ctrlHit && hwdata[`KDS_CTRL_ACK_BIT];

	wire scanEn   = ctrl_reg[`KDS_CTRL_EN_BIT];
	wire wideScan = ctrl_reg[`KDS_CTRL_WIDE_BIT];
	wire [2:0] lastDigit = wideScan ? 3'h7 : 3'(`KDS_NARROW_COLS - 1);
	wire [2:0] nextDigit = (digit_reg == lastDigit) ?
		3'h0 : digit_reg + 3'h1;
	// Narrow keypad strobes only the first four columns.
	wire colValid = wideScan || (digit_reg < 3'(`KDS_KEY_COLS));
	wire [7:0] decoded = decodeLow(digit_reg);

	wire [31:0] rdMux =
		(haddr == `KDS_CTRL_OFF)   ? ctrl_reg :
		(haddr == `KDS_STATUS_OFF) ?
			{29'h0, digit_reg == 3'h0, dbncPending, keyValid} :
		(haddr == `KDS_KEY_OFF)    ? {24'h0, keyCode} :
		(haddr == `KDS_SEG_OFF)    ? {24'h0, segLatch_reg} :
		((haddr & `KDS_TABLE_MASK) == `KDS_TABLE_OFF) ?
			{24'h0, table_reg[haddr[4:2]]} : 32'h0000_0000;

	tick_gen #(
		.PERIOD (TICK_CYCLES)
	) u_tick (
		.core_clk (core_clk),
		.reset    (reset),
		.clkEn    (clkEn),
		.run      (scanEn),
		.tick     (tick)
	);

	key_debounce u_key (
		.core_clk            (core_clk),
		.reset               (reset),
		.clkEn               (clkEn),
		.sample              (tick),
		.column              (digit_reg),
		.rowsLow             (rowSync_reg),
		.colValid            (colValid),
		.ackKey              (ackKey),
		.keyValidFlag        (keyValid),
		.debouncePendingFlag (dbncPending),
		.storedKeyCode       (keyCode)
	);

	// Scan sequence: tick reads keys, blanks, advances, then reloads.
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			kds_pkg::SCAN_IDLE:   if (tick) state_next = kds_pkg::SCAN_BLANK;
			kds_pkg::SCAN_BLANK:  state_next = kds_pkg::SCAN_SELECT;
			kds_pkg::SCAN_SELECT: state_next = kds_pkg::SCAN_LOAD;
			kds_pkg::SCAN_LOAD:   state_next = kds_pkg::SCAN_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			rowMeta_reg <= 5'h1F;
			rowSync_reg <= 5'h1F;
		end else if (clkEn) begin
			rowMeta_reg <= rowSenseLines;
			rowSync_reg <= rowMeta_reg;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			wrPend_reg <= 1'b0;
			rdPend_reg <= 1'b0;
			wrAddr_reg <= 32'h0000_0000;
			hrdata     <= 32'h0000_0000;
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
		end else if (clkEn) begin
			wrPend_reg <= wrAccept;
			rdPend_reg <= rdAccept;
			if (wrAccept) begin
				wrAddr_reg <= haddr;
			end
			if (rdAccept) begin
				hrdata <= rdMux;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			ctrl_reg <= `KDS_CTRL_RESET;
		end else if (clkEn && wrPend_reg && ctrlHit) begin
			ctrl_reg <= {30'h0, hwdata[1:0]};
		end
	end

	// The table is one of software's two paths to the display contents; the segment window writes the latch directly.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			for (int i = 0; i < 8; i++) begin
				table_reg[i] <= 8'h00;
			end
		end else if (clkEn && wrPend_reg && tableHit) begin
			table_reg[tableIdx] <= hwdata[7:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_reg    <= kds_pkg::SCAN_IDLE;
			digit_reg    <= 3'h0;
			segLatch_reg <= 8'h00;
			driveOn_reg  <= 1'b0;
		end else if (clkEn) begin
			state_reg <= state_next;
			if (state_reg == kds_pkg::SCAN_BLANK) begin
				segLatch_reg <= 8'h00;
				driveOn_reg  <= 1'b0;
			end else if (state_reg == kds_pkg::SCAN_SELECT) begin
				digit_reg <= nextDigit;
			end else if (state_reg == kds_pkg::SCAN_LOAD) begin
				segLatch_reg <= table_reg[digit_reg];
				driveOn_reg  <= 1'b1;
			end else if (segWrite) begin
				segLatch_reg <= hwdata[7:0];
			end
		end
	end

	// Driver stage: segments lead the digit enable by one cycle.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			segmentDrive     <= 8'h00;
			digitDrive       <= 7'h00;
			digitSelectLines <= 3'h0;
			driveLead_reg    <= 1'b0;
		end else if (clkEn) begin
			segmentDrive     <= segLatch_reg;
			digitSelectLines <= digit_reg;
			driveLead_reg    <= driveOn_reg;
			digitDrive       <= driveLead_reg ? ~decoded[6:0] : 7'h00;
		end
	end
endmodule

// *** test/kds_asserts.sv ***
/* Port checker of the scanner.
 * Assumes binding into keypad_display_scanner with scan writes apart. */
`timescale 1ns/100ps
module kds_asserts #(
	parameter int TICK_CYCLES = 20
) (
	input wire logic	core_clk,
	input wire logic	reset,
	input wire logic	hsel,
	input wire logic [31:0]	haddr,
	input wire logic [1:0]	htrans,
	input wire logic	hwrite,
	input wire logic [31:0]	hwdata,
	input wire logic	hready,
	input wire logic [2:0]	digitSelectLines,
	input wire logic [7:0]	segmentDrive,
	input wire logic [6:0]	digitDrive
);
	logic		segWr;
	logic [7:0]	wrByte;
	int		gap;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	// The gap count bounds how fast the digits may rotate.
	always_ff @(posedge core_clk) begin
		segWr <= !reset && hsel && hready && htrans[1] && hwrite
			&& haddr[15];
		if (segWr)
			wrByte <= hwdata[7:0];
		if (reset || $changed(digitSelectLines))
			gap <= 0;
		else
			gap <= gap + 1;
	end
	one_digit_a: assert property ($onehot0(digitDrive))
		else $error("more than one digit lit");
	tick_space_a: assert property ($changed(digitSelectLines)
		|-> gap >= TICK_CYCLES - 1) else $error("digit step too soon");
	seg_before_a: assert property ($rose(|digitDrive)
		|-> $stable(segmentDrive)) else $error("segments not set first");
	digit_decode_a: assert property (|digitDrive
		|-> digitDrive == 7'(8'h01 << digitSelectLines))
		else $error("drive does not match index");
	seven_only_a: assert property (digitSelectLines == 3'd7
		|-> digitDrive == 7'h00) else $error("eighth digit driven");
	seg_load_a: assert property (segWr
		|=> ##[0:1] segmentDrive == wrByte)
		else $error("segment latch not loaded");
	step_one_a: assert property ($changed(digitSelectLines)
		|-> digitSelectLines == 3'($past(digitSelectLines) + 3'd1)
		|| digitSelectLines == 3'd0) else $error("index skipped");
	blank_first_a: assert property ($changed(digitSelectLines)
		|-> digitDrive == 7'h00) else $error("digit lit on advance");
	reset_clear_a: assert property (disable iff (1'b0)
		$past(reset) |-> segmentDrive == 8'h00 && digitDrive == 7'h00
		&& digitSelectLines == 3'd0) else $error("reset not clear");
	cover property (digitDrive[6]);
	cover property (segWr);
	cover property (digitSelectLines == 3'd7);
endmodule
bind keypad_display_scanner kds_asserts #(.TICK_CYCLES(TICK_CYCLES))
	u_kds_asserts (.core_clk(core_clk), .reset(reset), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hready(hready), .digitSelectLines(digitSelectLines),
	.segmentDrive(segmentDrive), .digitDrive(digitDrive));

// *** test/keypad_model.sv ***
/* Key matrix holding at most one closed key.
 * Assumes rows with pull-ups, read through the column select. */
`timescale 1ns/100ps
module keypad_model (
	input  wire logic [2:0]	digitSelectLines,
	input  wire logic	keyOn,
	input  wire logic [2:0]	keyCol,
	input  wire logic [2:0]	keyRow,
	output logic [4:0]	rowSenseLines
);
	// An open row floats up to its pull-up level.
	assign rowSenseLines = (keyOn && digitSelectLines == keyCol) ?
		~(5'h01 << keyRow) : 5'h1F;
endmodule

// *** test/tb_keypad_display_scanner.sv ***
/* Bench of the scanner with a keypad model.
 * Assumes a 100 MHz clock and a shortened scan tick. */
`timescale 1ns/100ps
module tb_keypad_display_scanner;
	localparam int TICK = 20;
	logic		core_clk = 0;
	logic		reset = 1;
	logic		hsel = 0;
	logic		hwrite = 0;
	logic		keyOn = 0;
	logic		hreadyout;
	logic		hresp;
	logic [1:0]	htrans = 0;
	logic [31:0]	haddr = 0;
	logic [31:0]	hwdata = 0;
	logic [31:0]	hrdata;
	logic [31:0]	rd;
	logic [31:0]	d;
	logic [4:0]	rowSenseLines;
	logic [2:0]	digitSelectLines;
	logic [2:0]	keyCol = 0;
	logic [2:0]	keyRow = 0;
	logic [7:0]	segmentDrive;
	logic [6:0]	digitDrive;
	logic [7:0]	tbl [8];
	int		fails = 0;
	int		num_checks = 0;
	int		seed = 30872;
	int		n = 0;
	always #5 core_clk = ~core_clk;
	keypad_display_scanner #(.TICK_CYCLES(TICK)) u_keypad_display_scanner (
		.core_clk(core_clk), .reset(reset), .clkEn(1'b1), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp),
		.rowSenseLines(rowSenseLines),
		.digitSelectLines(digitSelectLines),
		.segmentDrive(segmentDrive), .digitDrive(digitDrive));
	keypad_model u_keypad_model (.digitSelectLines(digitSelectLines),
		.keyOn(keyOn), .keyCol(keyCol), .keyRow(keyRow),
		.rowSenseLines(rowSenseLines));
	function automatic logic [31:0] key_code(input logic [2:0] c, r);
		return {24'h0, 5'h1F ^ (5'h01 << r), c};
	endfunction
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask
	// One watchdog bounds every wait, so a hang ends in the report.
	task automatic cyc;
		@(posedge core_clk);
		n++;
		if (n > 20000) begin
			fails++;
			report_and_stop();
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, dw);
		hsel <= 1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= a;
		do cyc(); while (hreadyout !== 1'b1);
		hsel <= 0;
		htrans <= 2'b00;
		hwdata <= dw;
		do cyc(); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	initial begin
		for (int i = 0; i < 8; i++)
			tbl[i] = 8'($random(seed));
		repeat (8) @(posedge core_clk);
		reset <= 0;
		cyc();
		chk("segments", 0, segmentDrive);
		chk("drive", 0, digitDrive);
		chk("index", 0, digitSelectLines);
		bus(0, 32'h0000_0040, 0);
		chk("unmapped", 0, rd);
		chk("okay", 0, hresp);
		$display("test reset done");
		for (int i = 0; i < 8; i++)
			bus(1, 32'h0000_0020 + 32'(i * 4), {24'h0, tbl[i]});
		repeat (3 * TICK) cyc();
		repeat (16) begin
			do cyc(); while (digitDrive === 7'h00);
			chk("pattern", tbl[digitSelectLines], segmentDrive);
			chk("one hot", 8'h01 << digitSelectLines, digitDrive);
			do cyc(); while (digitDrive !== 7'h00);
		end
		bus(1, 32'h0000_0000, 3);
		do cyc(); while (digitSelectLines !== 3'd7);
		chk("eighth", 0, digitDrive);
		$display("test refresh done");
		bus(1, 32'h0000_0000, 0);
		repeat (4) begin
			d = {24'h0, 8'($random(seed))};
			bus(1, {16'h0, 1'b1, 15'($random(seed))}, d);
			bus(0, 32'h0000_000C, 0);
			chk("latch", d, rd);
			chk("latch pins", d, segmentDrive);
			bus(1, 32'h0000_7F10, ~d);
			bus(0, 32'h0000_000C, 0);
			chk("low write", d, rd);
		end
		$display("test latch done");
		bus(1, 32'h0000_0000, 1);
		bus(0, 32'h0000_0004, 0);
		chk("no key", 0, rd[0]);
		for (int i = 0; i < 3; i++) begin
			keyCol <= (i == 0) ? 3'd3 : 3'($unsigned($random(seed)) % 4);
			keyRow <= (i == 0) ? 3'd4 : 3'($unsigned($random(seed)) % 5);
			keyOn <= 1;
			do bus(0, 32'h0000_0004, 0); while (rd[1:0] === 2'b00);
			chk("first seen", 2, rd[1:0]);
			do bus(0, 32'h0000_0004, 0); while (rd[0] !== 1'b1);
			bus(0, 32'h0000_0008, 0);
			chk("key", key_code(keyCol, keyRow), rd);
			bus(1, 32'h0000_0000, 5);
			repeat (16 * TICK) cyc();
			bus(0, 32'h0000_0004, 0);
			chk("held key", 0, rd[0]);
			keyOn <= 0;
			repeat (16 * TICK) cyc();
		end
		$display("test keys done");
		report_and_stop();
	end
endmodule
